// *** sms_pkg.sv ***
/*
 * constants and types for the memory source sample recorder.
 * assumes a single core clock and active-low asynchronous reset.
 */
// What this block does
// - capture only when sampling on and double miss
// - line state flag: modified 0, owned 1
// - destination flag: local 0, remote 1
// - source codes 0,1,2,3,7; 4-6 never produced
// - source zero marks whole record invalid
// - local third-level cache only with local
// - code 2 local or remote core cache, or remote third-level cache
// - code 3 local or remote dram
// - code 7 remote never interrupt controller
// - record guaranteed only for loads
// - line state meaningful only for cache sources
// - miss latency valid only for loads
// - latency counts miss detect to fill
package sms_pkg;
   // ****************************************************************
   // source codes
   // ****************************************************************
   localparam logic [2:0] SMS_SRC_NONE = 3'h0;
   localparam logic [2:0] SMS_SRC_L3   = 3'h1;
   localparam logic [2:0] SMS_SRC_CACHE = 3'h2;
   localparam logic [2:0] SMS_SRC_DRAM = 3'h3;
   localparam logic [2:0] SMS_SRC_IO   = 3'h7;
   // ****************************************************************
   // hub supplier kinds and reset values
   // ****************************************************************
   localparam logic [2:0] SMS_KIND_L3      = 3'h0;
   localparam logic [2:0] SMS_KIND_CORE    = 3'h1;
   localparam logic [2:0] SMS_KIND_DRAM    = 3'h2;
   localparam logic [2:0] SMS_KIND_MMIO    = 3'h3;
   localparam logic [2:0] SMS_KIND_INTC    = 3'h4;
   localparam logic       SMS_ST_MODIFIED  = 1'h0;
   localparam logic       SMS_ST_OWNED     = 1'h1;
   localparam logic       SMS_DST_LOCAL    = 1'h0;
   localparam logic       SMS_DST_REMOTE   = 1'h1;
   localparam int         SMS_LAT_W        = 16;
   typedef enum logic [1:0] {
      SMS_IDLE = 2'b00,
      SMS_WAIT = 2'b01,
      SMS_DONE = 2'b11
   } sms_state_t;
endpackage : sms_pkg

// *** sms_encode.sv ***
/*
 * maps a hub supplier description onto source code and flags.
 * assumes kind and remote are stable while done is presented.
 */
module sms_encode
   import sms_pkg::*;
(
   input  wire logic [2:0] kind,
   input  wire logic       remote,
   input  wire logic       owned,
   output logic      [2:0] src,
   output logic            dst,
   output logic            st
);
   // ****************************************************************
   // encoding
   // ****************************************************************
   always_comb begin
      src = SMS_SRC_NONE;
      dst = SMS_DST_LOCAL;
      st  = SMS_ST_MODIFIED;
      case (kind)
         SMS_KIND_L3: begin
            // a remote third-level cache is reported as a cache source
            src = remote ? SMS_SRC_CACHE : SMS_SRC_L3;
            dst = remote;
            st  = owned ? SMS_ST_OWNED : SMS_ST_MODIFIED;
         end
         SMS_KIND_CORE: begin
            src = SMS_SRC_CACHE;
            dst = remote ? SMS_DST_REMOTE : SMS_DST_LOCAL;
            st  = owned ? SMS_ST_OWNED : SMS_ST_MODIFIED;
         end
         SMS_KIND_DRAM: begin
            src = SMS_SRC_DRAM;
            dst = remote;
         end
         SMS_KIND_MMIO: begin
            src = SMS_SRC_IO;
            dst = remote;
         end
         SMS_KIND_INTC: begin
            src = SMS_SRC_IO;
            dst = SMS_DST_LOCAL;
         end
         default: begin
            src = SMS_SRC_NONE;
         end
      endcase
   end
endmodule : sms_encode

// *** sms_recorder.sv ***
/*
 * memory source sample recorder: watches the tagged op's miss and the
 * hub completion, captures the supplier record and miss latency.
 * assumes a single tagged op per armed sample, inputs synchronous.
 */
module sms_recorder
   import sms_pkg::*;
#(
   parameter int LAT_W = SMS_LAT_W
)
(
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   input  wire logic             sampling_en,
   input  wire logic             arm,
   input  wire logic             tag_miss,
   input  wire logic             tag_is_load,
   input  wire logic             l1_miss,
   input  wire logic             l2_miss,
   input  wire logic             hub_done,
   input  wire logic [2:0]       hub_kind,
   input  wire logic             hub_remote,
   input  wire logic             hub_owned,
   input  wire logic             fill_done,
   input  wire logic             sample_read,
   output logic [2:0]            data_source_code,
   output logic                  remote_service_flag,
   output logic                  supplier_line_state,
   output logic                  record_valid,
   output logic                  latency_valid,
   output logic [LAT_W-1:0]      load_miss_latency,
   output logic                  busy
);
   // ****************************************************************
   // state
   // ****************************************************************
   sms_state_t       state_r, state_nxt;
   logic [2:0]       src_r, src_nxt;
   logic             dst_r, dst_nxt;
   logic             st_r, st_nxt;
   logic             load_r, load_nxt;
   logic             lat_on_r, lat_on_nxt;
   logic             lat_ok_r, lat_ok_nxt;
   logic [LAT_W-1:0] lat_r, lat_nxt;
   logic [2:0]       enc_src;
   logic             enc_dst;
   logic             enc_st;
   logic             start;

   sms_encode u_enc (
      .kind   (hub_kind),
      .remote (hub_remote),
      .owned  (hub_owned),
      .src    (enc_src),
      .dst    (enc_dst),
      .st     (enc_st)
   );

   assign start = sampling_en && tag_miss && l1_miss && l2_miss;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      state_nxt  = state_r;
      src_nxt    = src_r;
      dst_nxt    = dst_r;
      st_nxt     = st_r;
      load_nxt   = load_r;
      lat_on_nxt = lat_on_r;
      lat_ok_nxt = lat_ok_r;
      lat_nxt    = lat_r;
      if (lat_on_r && lat_r != '1) begin
         lat_nxt = lat_r + 1'b1;
      end
      if (lat_on_r && fill_done) begin
         lat_on_nxt = 1'b0;
         lat_ok_nxt = load_r;
      end
      case (state_r)
         SMS_IDLE: begin
            if (start && !arm) begin
               state_nxt  = SMS_WAIT;
               src_nxt    = SMS_SRC_NONE;
               load_nxt   = tag_is_load;
               lat_on_nxt = tag_is_load;
               lat_ok_nxt = 1'b0;
               lat_nxt    = '0;
            end
         end
         SMS_WAIT: begin
            if (arm || !sampling_en) begin
               state_nxt  = SMS_IDLE;
               lat_on_nxt = 1'b0;
            end else if (hub_done) begin
               state_nxt = SMS_DONE;
               src_nxt   = enc_src;
               dst_nxt   = enc_dst;
               st_nxt    = enc_st;
            end
         end
         SMS_DONE: begin
            // record stays frozen until read or rearm
            if (sample_read || arm) begin
               state_nxt  = SMS_IDLE;
               src_nxt    = SMS_SRC_NONE;
               lat_on_nxt = 1'b0;
               // a fill landing with the release still counts
               if (!(lat_on_r && fill_done)) begin
                  lat_ok_nxt = 1'b0;
               end
            end
         end
         default: begin
            state_nxt = SMS_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r  <= SMS_IDLE;
         src_r    <= SMS_SRC_NONE;
         dst_r    <= SMS_DST_LOCAL;
         st_r     <= SMS_ST_MODIFIED;
         load_r   <= 1'b0;
         lat_on_r <= 1'b0;
         lat_ok_r <= 1'b0;
         lat_r    <= '0;
      end else begin
         state_r  <= state_nxt;
         src_r    <= src_nxt;
         dst_r    <= dst_nxt;
         st_r     <= st_nxt;
         load_r   <= load_nxt;
         lat_on_r <= lat_on_nxt;
         lat_ok_r <= lat_ok_nxt;
         lat_r    <= lat_nxt;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign data_source_code    = src_r;
   assign remote_service_flag = dst_r;
   assign supplier_line_state = st_r;
   // stores never claim a valid record, zero source voids it
   assign record_valid = (state_r == SMS_DONE) && load_r
                         && (src_r != SMS_SRC_NONE);
   assign latency_valid     = lat_ok_r && load_r;
   assign load_miss_latency = lat_r;
   assign busy              = (state_r != SMS_IDLE);

   // ****************************************************************
   // checks
   // ****************************************************************
   chk_no_reserved: assert property (@(posedge core_clk) disable iff (!rst_b)
      !(src_r inside {3'h4, 3'h5, 3'h6}))
      else $error("reserved source code");
   chk_l3_local: assert property (@(posedge core_clk) disable iff (!rst_b)
      (src_r == SMS_SRC_L3) |-> (dst_r == SMS_DST_LOCAL))
      else $error("local l3 reported remote");
   chk_zero_invalid: assert property (@(posedge core_clk) disable iff (!rst_b)
      (src_r == SMS_SRC_NONE) |-> !record_valid)
      else $error("zero source reported valid");
   chk_store_invalid: assert property (@(posedge core_clk)
      disable iff (!rst_b) !load_r |-> !record_valid && !latency_valid)
      else $error("store record marked valid");
   chk_capture_cause: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      $rose(busy) |-> $past(sampling_en && l1_miss && l2_miss))
      else $error("capture without double miss");
   chk_hold_record: assert property (@(posedge core_clk) disable iff (!rst_b)
      (state_r == SMS_DONE && !sample_read && !arm)
      |=> $stable(src_r) && $stable(dst_r) && $stable(st_r))
      else $error("record changed while held");
   chk_hub_encode: assert property (@(posedge core_clk) disable iff (!rst_b)
      (state_r == SMS_WAIT && hub_done && !arm && sampling_en
       && hub_kind == SMS_KIND_DRAM)
      |=> src_r == SMS_SRC_DRAM && dst_r == $past(hub_remote))
      else $error("dram source misencoded");
   chk_intc_local: assert property (@(posedge core_clk) disable iff (!rst_b)
      (state_r == SMS_WAIT && hub_done && !arm && sampling_en
       && hub_kind == SMS_KIND_INTC)
      |=> src_r == SMS_SRC_IO && !dst_r)
      else $error("interrupt controller reported remote");
   chk_lat_count: assert property (@(posedge core_clk) disable iff (!rst_b)
      (lat_on_r && !fill_done && lat_r < 16'h00ff && state_r == SMS_WAIT
       && !arm && sampling_en) |=> lat_r == $past(lat_r) + 1'b1)
      else $error("latency not counting");
   chk_capture_load: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      $rose(busy) |-> load_r == $past(tag_is_load))
      else $error("load flag not captured");
   chk_abort_idle: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (state_r == SMS_WAIT && (arm || !sampling_en))
      |=> state_r == SMS_IDLE && !record_valid)
      else $error("abort did not return to idle");
   chk_start_clear: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (state_r == SMS_IDLE && start && !arm)
      |=> busy && lat_r == '0 && lat_on_r == $past(tag_is_load))
      else $error("capture start not clean");
   chk_lat_stop: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (lat_on_r && fill_done)
      |=> !lat_on_r && latency_valid == $past(load_r))
      else $error("latency not closed on fill");
   chk_core_cache: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (state_r == SMS_WAIT && hub_done && !arm && sampling_en
       && hub_kind == SMS_KIND_CORE)
      |=> src_r == SMS_SRC_CACHE && dst_r == $past(hub_remote)
          && st_r == $past(hub_owned))
      else $error("core cache source misencoded");
   cov_dram_load: cover property (@(posedge core_clk)
      record_valid && src_r == SMS_SRC_DRAM);
   cov_remote_cache: cover property (@(posedge core_clk)
      record_valid && src_r == SMS_SRC_CACHE && dst_r);
   cov_latency: cover property (@(posedge core_clk) $rose(latency_valid));
   cov_read_clear: cover property (@(posedge core_clk)
      state_r == SMS_DONE && sample_read);
   cov_abort: cover property (@(posedge core_clk)
      state_r == SMS_WAIT && (arm || !sampling_en));
endmodule : sms_recorder

// *** sms_hub_model.sv ***
/*
 * load pipeline and memory hub partner for the sample recorder.
 * assumes the bench calls run from one process at a time.
 */
module sms_hub_model
   import sms_pkg::*;
(
   input  wire logic       core_clk,
   output logic            tag_miss,
   output logic            tag_is_load,
   output logic            l1_miss,
   output logic            l2_miss,
   output logic            hub_done,
   output logic [2:0]      hub_kind,
   output logic            hub_remote,
   output logic            hub_owned,
   output logic            fill_done
);
   // ****************************************************************
   // one tagged op: miss, completion after d, fill e later
   // ****************************************************************
   initial begin
      {tag_miss, tag_is_load, l1_miss, l2_miss} = 4'h0;
      {hub_done, hub_kind, hub_remote, hub_owned, fill_done} = 7'h00;
   end
   task automatic run(input logic [2:0] k, input logic r, o, ld, m1, m2,
                      input int d, e);
      @(negedge core_clk);
      {tag_miss, tag_is_load, l1_miss, l2_miss} = {1'b1, ld, m1, m2};
      for (int i = 0; i < d + e; i++) begin
         @(negedge core_clk);
         // released lines never keep their last value
         {tag_miss, tag_is_load, l1_miss, l2_miss} = {1'b0, ~ld, ~m1, ~m2};
         hub_done = (i == d - 1);
         fill_done = (i == d + e - 1);
         {hub_kind, hub_remote, hub_owned} = hub_done ? {k, r, o} :
            {hub_kind + 3'h3, ~hub_remote, ~hub_owned};
      end
      @(negedge core_clk);
      {hub_done, fill_done} = 2'b00;
   endtask : run
endmodule : sms_hub_model

// *** tb.sv ***
/*
 * self-checking bench for the memory source sample recorder.
 * assumes the hub partner model drives all pipeline and hub inputs.
 */
module tb
   import sms_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************************************
   // signals, design and partner
   // ****************************************************************
   logic        core_clk, rst_b, sampling_en, arm, sample_read;
   logic        tag_miss, tag_is_load, l1_miss, l2_miss, hub_done;
   logic        hub_owned, hub_remote, fill_done, busy;
   logic [2:0]  hub_kind, data_source_code;
   logic        remote_service_flag, supplier_line_state;
   logic        record_valid, latency_valid;
   logic [15:0] load_miss_latency;
   int          n_fail = 0;
   int          tests_run = 0;
   int          cycles = 0;
   int          seed = 32'h6168;

   sms_recorder i_sms_recorder (.core_clk, .rst_b, .sampling_en, .arm,
      .tag_miss, .tag_is_load, .l1_miss, .l2_miss, .hub_done, .hub_kind,
      .hub_remote, .hub_owned, .fill_done, .sample_read, .data_source_code,
      .remote_service_flag, .supplier_line_state, .record_valid,
      .latency_valid, .load_miss_latency, .busy);
   sms_hub_model i_sms_hub_model (.core_clk, .tag_miss, .tag_is_load,
      .l1_miss, .l2_miss, .hub_done, .hub_kind, .hub_remote, .hub_owned,
      .fill_done);

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles > 5000) begin
         n_fail++;
         wrap_up();
      end
   end
   // ****************************************************************
   // compare, reference model and closing
   // ****************************************************************
   task automatic check(input string what, input logic [15:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wrap_up;
      $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   task automatic release_rec;
      sample_read = 1'b1;
      @(negedge core_clk);
      sample_read = 1'b0;
      @(negedge core_clk);
      check("busy", busy, 0);
      check("record_valid", record_valid, 0);
      check("latency_valid", latency_valid, 0);
   endtask : release_rec

   task automatic one(input int k, r, o, ld, d, e);
      int src;
      int dst;
      src = (k == 0) ? 1 + r : (k == 1) ? 2 : (k == 2) ? 3 : (k < 5) ? 7 : 0;
      dst = (k == 4) ? 0 : r;
      i_sms_hub_model.run(k[2:0], r[0], o[0], ld[0], 1'b1, 1'b1, d, e);
      check("busy", busy, 1);
      check("record_valid", record_valid, ld && src != 0);
      check("latency_valid", latency_valid, ld);
      if (ld) check("latency", load_miss_latency, d + e);
      if (ld) check("source", data_source_code, src);
      if (ld && src) check("dest", remote_service_flag, dst);
      if (ld && src == 2) check("state", supplier_line_state, o);
      if (ld && src > 2) check("state", supplier_line_state, 0);
      repeat (3) @(negedge core_clk);
      if (ld) check("held source", data_source_code, src);
      check("held valid", record_valid, ld && src != 0);
      release_rec();
   endtask : one
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      {rst_b, sampling_en, arm, sample_read} = 4'h0;
      repeat (10) @(negedge core_clk);
      check("reset source", data_source_code, 0);
      check("reset busy", busy, 0);
      rst_b = 1'b1;
      i_sms_hub_model.run(3'h2, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 2, 2);
      check("busy off", busy, 0);
      sampling_en = 1'b1;
      for (int m = 0; m < 3; m++) begin
         i_sms_hub_model.run(3'h2, 1'b0, 1'b0, 1'b1, m[0], m[1], 2, 2);
         check("busy single miss", busy, 0);
         check("valid single miss", record_valid, 0);
      end
      for (int i = 0; i < 24; i++) begin
         one(i < 16 ? i / 2 : $random(seed) & 7, i < 16 ? i % 2 :
             $random(seed) & 1, $random(seed) & 1, i < 16 ? 1 :
             i < 18 ? 0 : $random(seed) & 1, 1 + ($random(seed) & 7),
             1 + ($random(seed) & 15));
      end
      // abort by rearm, by sampling off, by reset in mid-run
      for (int a = 0; a < 3; a++) begin
         fork
            i_sms_hub_model.run(3'h2, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4, 2);
            begin
               repeat (2) @(negedge core_clk);
               {arm, sampling_en, rst_b} = {a == 0, a != 1, a != 2};
               @(negedge core_clk);
               {arm, sampling_en, rst_b} = 3'b011;
            end
         join
         check("abort busy", busy, 0);
         check("abort valid", record_valid, 0);
         check("abort latency", latency_valid, 0);
         check("abort source", data_source_code, 0);
      end
      wrap_up();
   end
endmodule : tb
